// File: secded_host_params.svh
// Register offsets, field positions, reset values and timing counts for the SECDED host
`ifndef SECDED_HOST_PARAMS_SVH
`define SECDED_HOST_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DATA_LO 8'h04
`define OFS_DATA_HI 8'h08
`define OFS_MEM_CHECK 8'h0C
`define OFS_STATUS 8'h10
`define OFS_CHECK_OUT 8'h14
`define OFS_SYNDROME 8'h18
`define OFS_CORR_LO 8'h1C
`define OFS_CORR_HI 8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_GEN_BIT 0
`define CTRL_CORR_BIT 1
`define CTRL_TMODE_LSB 2
`define CTRL_PASS_BIT 4
`define CTRL_WCODE_LSB 5
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_ANY_BIT 2
`define STAT_MULTI_BIT 3
`define STAT_DOUBLE_BIT 4
`define STAT_INVALID_BIT 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WCODE_RST 3'h6
`define TMODE_RST 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SETTLE_NS 300
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2
`define WAIT_CYC (`SETTLE_CYC + `SYNC_STAGES)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: secded_host_pkg.sv
// Types shared by the SECDED cascade host
package secded_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DRIVE = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_FEED = 3'h2,
    ST_CAPT = 3'h6
  } host_state_t;

  typedef logic [6:0] slice_check_t;

endpackage

// File: pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = pin_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule

// File: secded_host.sv
// Host controller for a four-slice 64-bit SECDED cascade, with AXI4-Lite registers
//
// Overview of operation
// - Host forms final check and syndrome bits with XOR gates outside the slices.
// - Host feeds syndromes onto check inputs 0-6, selecting against memory check bits.
// - Host must not trust output data when a double or multiple error shows.
// - In pass-through the check latch shows inverted on the final XOR outputs.
// - In diagnostic generate the diagnostic latch shows inverted on XOR outputs.
// - Data bits 16-31 go to upper slice inputs 0-15, 0-15 to lower.
// - 32-bit correction feeds upper slice syndromes into lower slice check inputs.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "secded_host_params.svh"
module secded_host
  import secded_host_pkg::*;
#(
  parameter int SLICES = 4,
  parameter int WAIT_CYCLES = `WAIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Slice cascade pins out
  output logic [63:0] slice_data_o,
  output logic [6:0] check_bit_inputs_o,
  output logic mem_buf_oe_n_o,
  output logic synd_buf_oe_n_o,
  output logic [2:0] width_select_code_o,
  output logic [1:0] test_mode_select_o,
  output logic fix_enable_o,
  output logic pass_thru_o,
  output logic syndrome_output_enable_n_o,
  // Slice cascade pins in
  input wire logic [63:0] slice_data_i,
  input wire logic [4*7-1:0] syndrome_check_outputs_i,
  input wire logic [3:0] any_fault_n_i,
  input wire logic [3:0] multi_fault_n_i
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_double(input logic [7:0] syn);
    return (syn != 8'h00) && !(^syn);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [99:0] pins_s;
  pin_sync #(.WIDTH(100)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i({multi_fault_n_i, any_fault_n_i, syndrome_check_outputs_i, slice_data_i}),
    .sync_o(pins_s)
  );
  logic [63:0] cdata_s;
  slice_check_t sc_s [4];
  logic [3:0] any_n_s;
  logic [3:0] multi_n_s;
  always_comb begin
    cdata_s = pins_s[63:0];
    for (int s = 0; s < 4; s++) begin
      sc_s[s] = pins_s[64 + s*7 +: 7];
    end
    any_n_s = pins_s[95:92];
    multi_n_s = pins_s[99:96];
  end

  // External XOR fold of slice partials; bit 6 of each slice is its high-weight partial
  logic [7:0] fold;
  always_comb begin
    fold = 8'h00;
    for (int i = 0; i < 6; i++) begin
      fold[i] = sc_s[0][i] ^ sc_s[1][i] ^ sc_s[2][i] ^ sc_s[3][i];
    end
    // Slices 0 and 1 give one byte to both C16 and C32; slices 2 and 3 give their
    // other byte through the C8 partial, as one output cannot carry both
    fold[6] = sc_s[0][6] ^ sc_s[1][6] ^ sc_s[2][6] ^ sc_s[3][5];
    fold[7] = sc_s[0][6] ^ sc_s[1][6] ^ sc_s[2][5] ^ sc_s[3][6];
  end

  // ----------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------
  host_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic corr_req_q, corr_req_d;
  logic [63:0] data_q, data_d, corr_q, corr_d;
  logic [7:0] memchk_q, memchk_d, chk_q, chk_d, syn_q, syn_d;
  logic [2:0] wcode_q, wcode_d;
  logic [1:0] tmode_q, tmode_d;
  logic pass_q, pass_d;
  logic done_q, done_d, any_q, any_d, multi_q, multi_d, dbl_q, dbl_d, inval_q, inval_d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] syn_now;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    corr_req_d = corr_req_q;
    data_d = data_q;
    corr_d = corr_q;
    memchk_d = memchk_q;
    chk_d = chk_q;
    syn_d = syn_q;
    wcode_d = wcode_q;
    tmode_d = tmode_q;
    pass_d = pass_q;
    done_d = done_q;
    any_d = any_q;
    multi_d = multi_q;
    dbl_d = dbl_q;
    inval_d = inval_q;
    syn_now = fold ^ memchk_q;
    if (wr_en) begin
      case (wr_addr)
        `OFS_CTRL: begin
          if (wr_strb[0]) begin
            tmode_d = wr_data[`CTRL_TMODE_LSB +: 2];
            pass_d = wr_data[`CTRL_PASS_BIT];
            wcode_d = wr_data[`CTRL_WCODE_LSB +: 3];
            // A start while busy is dropped
            if (st_q == ST_IDLE && (wr_data[`CTRL_GEN_BIT] || wr_data[`CTRL_CORR_BIT])) begin
              st_d = ST_DRIVE;
              cnt_d = 4'h0;
              corr_req_d = wr_data[`CTRL_CORR_BIT];
            end
          end
        end
        `OFS_DATA_LO: data_d[31:0] = apply_strb(data_q[31:0], wr_data, wr_strb);
        `OFS_DATA_HI: data_d[63:32] = apply_strb(data_q[63:32], wr_data, wr_strb);
        `OFS_MEM_CHECK: begin
          if (wr_strb[0]) begin
            memchk_d = wr_data[7:0];
          end
        end
        `OFS_STATUS: begin
          if (wr_strb[0] && wr_data[`STAT_DONE_BIT]) begin
            done_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    case (st_q)
      ST_DRIVE, ST_FEED: begin
        // Slices and synchronisers need time before their outputs mean anything
        if (cnt_q == 4'(WAIT_CYCLES - 1)) begin
          st_d = (st_q == ST_DRIVE) ? ST_SAMPLE : ST_CAPT;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      ST_SAMPLE: begin
        chk_d = fold;
        syn_d = syn_now;
        any_d = (syn_now != 8'h00) || (any_n_s != 4'hF);
        // Slice multiple-fault pins only mean something once syndromes are fed back
        multi_d = 1'b0;
        dbl_d = is_double(syn_now);
        inval_d = is_double(syn_now);
        cnt_d = 4'h0;
        st_d = corr_req_q ? ST_FEED : ST_IDLE;
        if (!corr_req_q) begin
          done_d = 1'b1;
        end
      end
      ST_CAPT: begin
        multi_d = (multi_n_s != 4'hF);
        inval_d = dbl_q || (multi_n_s != 4'hF);
        // Corrected word is worthless after a double or multiple error
        if (!dbl_q && (multi_n_s == 4'hF)) begin
          corr_d = cdata_s;
        end
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
      ST_IDLE: begin
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      corr_req_q <= 1'b0;
      data_q <= 64'h0;
      corr_q <= 64'h0;
      memchk_q <= 8'h00;
      chk_q <= 8'h00;
      syn_q <= 8'h00;
      wcode_q <= `WCODE_RST;
      tmode_q <= `TMODE_RST;
      pass_q <= 1'b0;
      done_q <= 1'b0;
      any_q <= 1'b0;
      multi_q <= 1'b0;
      dbl_q <= 1'b0;
      inval_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      corr_req_q <= corr_req_d;
      data_q <= data_d;
      corr_q <= corr_d;
      memchk_q <= memchk_d;
      chk_q <= chk_d;
      syn_q <= syn_d;
      wcode_q <= wcode_d;
      tmode_q <= tmode_d;
      pass_q <= pass_d;
      done_q <= done_d;
      any_q <= any_d;
      multi_q <= multi_d;
      dbl_q <= dbl_d;
      inval_q <= inval_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic feeding;
  assign feeding = (st_q == ST_FEED) || (st_q == ST_CAPT);
  assign slice_data_o = data_q;
  assign check_bit_inputs_o = syn_q[6:0];
  assign synd_buf_oe_n_o = !feeding;
  assign mem_buf_oe_n_o = feeding;
  assign fix_enable_o = feeding;
  assign width_select_code_o = wcode_q;
  assign test_mode_select_o = tmode_q;
  assign pass_thru_o = pass_q;
  assign syndrome_output_enable_n_o = 1'b0;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o = !w_hold_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign wr_en = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  function automatic logic mapped(input logic [7:0] a);
    return (a <= `OFS_CORR_HI) && (a[1:0] == 2'h0);
  endfunction

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (wr_en) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr_i) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr_i)
        `OFS_CTRL: rdata_d = {24'h0, wcode_q, pass_q, tmode_q, 2'h0};
        `OFS_DATA_LO: rdata_d = data_q[31:0];
        `OFS_DATA_HI: rdata_d = data_q[63:32];
        `OFS_MEM_CHECK: rdata_d = {24'h0, memchk_q};
        `OFS_STATUS: rdata_d = {26'h0, inval_q, dbl_q, multi_q, any_q, done_q,
                                st_q != ST_IDLE};
        `OFS_CHECK_OUT: rdata_d = {24'h0, chk_q};
        `OFS_SYNDROME: rdata_d = {24'h0, syn_q};
        `OFS_CORR_LO: rdata_d = corr_q[31:0];
        `OFS_CORR_HI: rdata_d = corr_q[63:32];
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_buf_select_excl: assert property (mem_buf_oe_n_o != synd_buf_oe_n_o)
    else $error("Both or neither check-bit buffer enabled");
  a_feed_with_fix: assert property (!synd_buf_oe_n_o |-> fix_enable_o && st_q != ST_DRIVE)
    else $error("Syndrome fed back outside correction");
  a_feed_value: assert property (feeding |-> check_bit_inputs_o == syn_q[6:0]
                                 ##1 (!feeding || $stable(syn_q)))
    else $error("Fed-back syndrome differs from stored syndrome");
  a_synd_xor: assert property (st_q == ST_SAMPLE |=> syn_q == (chk_q ^ memchk_q))
    else $error("Syndrome is not generated XOR read check bits");
  a_check_fold: assert property (st_q == ST_SAMPLE |=> chk_q[7] == $past(sc_s[0][6] ^ sc_s[1][6]
                                 ^ sc_s[2][5] ^ sc_s[3][6]))
    else $error("Top check bit not folded from slice partials");
  a_any_combine: assert property (st_q == ST_SAMPLE
                                  && (any_n_s != 4'hF || syn_now != 8'h00) |=> any_q)
    else $error("Slice fault not reflected in combined fault");
  a_bad_keeps: assert property (st_q == ST_CAPT ##1 inval_q |-> $stable(corr_q))
    else $error("Corrected word taken after uncorrectable error");
  a_settle_wait: assert property (st_q == ST_SAMPLE |-> $past(st_q == ST_DRIVE, WAIT_CYCLES)
                                  && $past(st_q != ST_DRIVE, WAIT_CYCLES + 1))
    else $error("Sample taken before slices settled");
  a_data_drive: assert property (st_q != ST_IDLE |-> $stable(slice_data_o))
    else $error("Slice data changed during an operation");
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("Write response dropped before taken");

  c_gen_done: cover property (st_q == ST_SAMPLE && !corr_req_q ##1 st_q == ST_IDLE);
  c_corr_done: cover property (st_q == ST_CAPT && !inval_q);
  c_double_seen: cover property ($rose(dbl_q));
  c_read_taken: cover property (s_axi_rvalid_o && s_axi_rready_i);

endmodule

// File: secded_ref_pkg.sv
// Reference check-bit code of the 64-bit cascade, shared by the slice model and the bench
package secded_ref_pkg;

  // Rows X,0,1,2,4,8,16,32 of the check-bit code; bit i set when data bit i takes part
  localparam logic [63:0] CODE_MASK [8] = '{
    64'hB4D1_B4D1_4B2E_4B2E, 64'h1557_1557_1557_1557,
    64'hA699_A699_A699_A699, 64'h38E3_38E3_38E3_38E3,
    64'hC0FC_C0FC_C0FC_C0FC, 64'hFF00_FF00_FF00_FF00,
    64'hFF00_00FF_FF00_00FF, 64'h00FF_FF00_FF00_00FF};

  function automatic logic [7:0] ref_check(input logic [63:0] d);
    for (int k = 0; k < 8; k++) begin
      ref_check[k] = ^(d & CODE_MASK[k]) ^ (k == 2 || k == 3);
    end
  endfunction

endpackage

// File: slice_cascade_model.sv
// Behavioural model of the four correction slices as the host sees them at its pins
`timescale 1ns/1ns
module slice_cascade_model
  import secded_ref_pkg::*;
(
  // From the host
  input wire logic [63:0] data_i,
  input wire logic [6:0] check_bits_i,
  input wire logic mem_oe_n_i,
  input wire logic synd_oe_n_i,
  input wire logic fix_i,
  input wire logic sc_oe_n_i,
  // To the host
  output logic [63:0] data_o,
  output logic [27:0] sc_o,
  output logic [3:0] any_n_o,
  output logic [3:0] multi_n_o
);
  logic fb_on;
  logic hit;
  logic [6:0] col;
  logic [27:0] part;

  always_comb begin
    // Slices only use fed-back syndromes when that buffer alone drives them
    fb_on = !synd_oe_n_i && mem_oe_n_i && fix_i;
    data_o = data_i;
    hit = 1'b0;
    for (int i = 0; i < 64; i++) begin
      for (int k = 0; k < 7; k++) begin
        col[k] = CODE_MASK[k][i];
      end
      if (fb_on && check_bits_i == col) begin
        data_o[i] = !data_i[i];
        hit = 1'b1;
      end
    end
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 6; k++) begin
        part[7*s+k] = ^(data_i[16*s+:16] & CODE_MASK[k][16*s+:16])
                      ^ (s == 0 && k > 1 && k < 4);
      end
      // Bit 6 is the byte a slice gives to C16, or to C32 for the top slice
      part[7*s+6] = ^(data_i[16*s+:16] & CODE_MASK[(s == 3) ? 7 : 6][16*s+:16]);
      any_n_o[s] = !(fb_on && check_bits_i != 7'h00);
      multi_n_o[s] = !(fb_on && check_bits_i != 7'h00 && !hit
                       && $countones(check_bits_i) != 1);
    end
    // Disabled outputs float; show the inverse so a stale value never looks right
    sc_o = sc_oe_n_i ? ~part : part;
  end
endmodule

// File: tb_top.sv
// Self-checking bench of the cascade host, driven over AXI4-Lite
`timescale 1ns/1ns
`include "secded_host_params.svh"
module tb_top
  import secded_ref_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, test_mode_select_o;
  logic [63:0] slice_data_o, slice_data_i;
  logic [6:0] check_bit_inputs_o;
  logic mem_buf_oe_n_o, synd_buf_oe_n_o, fix_enable_o, pass_thru_o, syndrome_output_enable_n_o;
  logic [2:0] width_select_code_o;
  logic [27:0] syndrome_check_outputs_i;
  logic [3:0] any_fault_n_i, multi_fault_n_i;
  int errors = 0, checks_done = 0, cycles = 0;
  // Cases: singles in data, single in check bit 32, clean, double, triple
  localparam logic [63:0] dflip [8] = '{64'h1, 64'h2_0000, 64'h100_0000_0000,
    64'h8000_0000_0000_0000, 64'h0, 64'h0, 64'h0004_0000_0000_0008, 64'hB};
  localparam logic [7:0] cflip [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  // Expected status {invalid, double, multi, any}
  localparam logic [3:0] stat [8] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0, 4'hF, 4'hB};
  localparam logic [63:0] gdata [3] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0123_4567_89AB_CDEF};
  localparam logic [63:0] clean = 64'h0123_4567_89AB_CDEF;

  // Short settle count keeps the run brief; the slice model has no delay
  secded_host #(.SLICES(4), .WAIT_CYCLES(3)) u_dut (.sys_clk_i, .rst_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .slice_data_o, .check_bit_inputs_o, .mem_buf_oe_n_o,
    .synd_buf_oe_n_o, .width_select_code_o, .test_mode_select_o, .fix_enable_o, .pass_thru_o,
    .syndrome_output_enable_n_o, .slice_data_i, .syndrome_check_outputs_i, .any_fault_n_i,
    .multi_fault_n_i);

  slice_cascade_model u_slices (.data_i(slice_data_o), .check_bits_i(check_bit_inputs_o),
    .mem_oe_n_i(mem_buf_oe_n_o), .synd_oe_n_i(synd_buf_oe_n_o), .fix_i(fix_enable_o),
    .sc_oe_n_i(syndrome_output_enable_n_o), .data_o(slice_data_i),
    .sc_o(syndrome_check_outputs_i), .any_n_o(any_fault_n_i), .multi_n_o(multi_fault_n_i));

  always #50 sys_clk_i = !sys_clk_i;

  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge sys_clk_i);
      aw_hs = s_axi_awvalid_i && s_axi_awready_o;
      w_hs = s_axi_wvalid_i && s_axi_wready_o;
      b_hs = s_axi_bvalid_o === 1'b1;
      if (b_hs) check(s_axi_bresp_o, er);
      @(posedge sys_clk_i);
      if (aw_hs) s_axi_awvalid_i <= 1'b0;
      if (w_hs) s_axi_wvalid_i <= 1'b0;
    end
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q, input logic [1:0] er);
    logic ar_hs, r_hs;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge sys_clk_i);
      ar_hs = s_axi_arvalid_i && s_axi_arready_o;
      r_hs = s_axi_rvalid_o === 1'b1;
      q = s_axi_rdata_o;
      if (r_hs) check(s_axi_rresp_o, er);
      @(posedge sys_clk_i);
      if (ar_hs) s_axi_arvalid_i <= 1'b0;
    end
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q, `RESP_OKAY);
    check(q, exp);
  endtask

  task automatic load(input logic [63:0] d, input logic [7:0] mc);
    wr(`OFS_DATA_LO, d[31:0], `RESP_OKAY);
    wr(`OFS_DATA_HI, d[63:32], `RESP_OKAY);
    wr(`OFS_MEM_CHECK, {24'h0, mc}, `RESP_OKAY);
  endtask

  task automatic run_op(input logic [31:0] ctrl);
    logic [31:0] q;
    wr(`OFS_STATUS, 32'h0000_0002, `RESP_OKAY);
    wr(`OFS_CTRL, ctrl, `RESP_OKAY);
    q = 32'h0;
    while (q[`STAT_DONE_BIT] !== 1'b1) rd(`OFS_STATUS, q, `RESP_OKAY);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Both buffers on at once would short memory check bits against syndromes
  always @(negedge sys_clk_i) begin
    if (!rst_i && (mem_buf_oe_n_o === synd_buf_oe_n_o
                   || (!synd_buf_oe_n_o && !fix_enable_o))) begin
      errors++;
      $display("wrong value at %0t: check-bit buffer enables clash", $time);
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      $display("wrong value at %0t: run did not complete", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [63:0] bad;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    check(width_select_code_o, `WCODE_RST);
    check(syndrome_output_enable_n_o, 1'b0);
    rdc(`OFS_CTRL, 32'h0000_00C0);
    rdc(`OFS_STATUS, 32'h0);
    rd(8'h24, q, `RESP_SLVERR);
    check(q, 32'h0);
    wr(8'h06, 32'h0000_00FF, `RESP_SLVERR);
    rdc(`OFS_CTRL, 32'h0000_00C0);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_CTRL, 32'h0000_00D0 | (m << 2), `RESP_OKAY);
      check({pass_thru_o, test_mode_select_o}, {1'b1, m[1:0]});
    end
    wr(`OFS_CTRL, 32'h0000_00C0, `RESP_OKAY);
    for (int g = 0; g < 3; g++) begin
      load(gdata[g], 8'h5A);
      run_op(32'h0000_00C1);
      rdc(`OFS_CHECK_OUT, {24'h0, ref_check(gdata[g])});
      rdc(`OFS_SYNDROME, {24'h0, ref_check(gdata[g]) ^ 8'h5A});
    end
    for (int c = 0; c < 8; c++) begin
      bad = clean ^ dflip[c];
      load(bad, ref_check(clean) ^ cflip[c]);
      run_op(32'h0000_00C2);
      rdc(`OFS_SYNDROME, {24'h0, ref_check(bad) ^ ref_check(clean) ^ cflip[c]});
      rd(`OFS_STATUS, q, `RESP_OKAY);
      check(q[5:2], stat[c]);
      rdc(`OFS_CORR_LO, clean[31:0]);
      rdc(`OFS_CORR_HI, clean[63:32]);
    end
    tally_and_finish();
  end
endmodule
